// file: oscms_consts.vh
`ifndef OSCMS_CONSTS_VH
`define OSCMS_CONSTS_VH
// register byte addresses (word aligned)
`define OSCMS_ADDR_CTRL      4'h0
`define OSCMS_ADDR_IRQ_STAT  4'h4
`define OSCMS_ADDR_IRQ_EN    4'h8
`define OSCMS_ADDR_IRQ_CLR   4'hc
// oscillator_control fields
`define OSCMS_F_SCS          0
`define OSCMS_F_LTS          1
`define OSCMS_F_HTS          2
`define OSCMS_F_RUNNING_ON_EXTERNAL_FLAG         3
`define OSCMS_F_INTERNAL_FREQ_CHOICE_LO      4
`define OSCMS_F_INTERNAL_FREQ_CHOICE_HI      6
`define OSCMS_INTERNAL_FREQ_CHOICE_RESET     3'h6
`define OSCMS_INTERNAL_FREQ_CHOICE_SLOW      3'h0
// clock modes of the configuration field
`define OSCMS_MODE_LP        3'h0
`define OSCMS_MODE_XT        3'h1
`define OSCMS_MODE_HS        3'h2
`define OSCMS_MODE_EC        3'h3
`define OSCMS_MODE_RESISTOR_CAP_PIN_IO_MODE      3'h4
`define OSCMS_MODE_RC        3'h5
`define OSCMS_MODE_INTIO     3'h6
`define OSCMS_MODE_INT       3'h7
// timing
`define OSCMS_OST_COUNT      11'h400
`define OSCMS_FAIL_CYCLES    8'h40
`define OSCMS_HF_WARM_CYCLES 8'h10
`define OSCMS_LF_WARM_CYCLES 8'h08
// interrupt status bits
`define OSCMS_EV_FAIL        0
`define OSCMS_EV_OST_DONE    1
`define OSCMS_EV_HF_STABLE   2
`define OSCMS_EV_SWITCHED    3
`endif

// file: oscms_top.v
`include "oscms_consts.vh"
`default_nettype none
module oscms_top #(
  parameter [7:0] FAIL_CYCLES = `OSCMS_FAIL_CYCLES
) (
  // system
  input  wire        clk_sys,
  input  wire        rst_n,
  // configuration and power events
  input  wire [2:0]  clock_mode_config,
  input  wire        two_speed_cfg,
  input  wire        fail_monitor_cfg,
  input  wire        power_up_delay_done,
  input  wire        wake_from_sleep,
  // oscillator pins
  input  wire        oscillator_in_pin,
  output wire        oscillator_out_o,
  output wire        oscillator_out_oe,
  output wire        osc_in_is_gpio,
  output wire        osc_out_is_gpio,
  // clock status
  output wire        fast_osc_enable,
  output wire        use_external_clk,
  output wire [2:0]  internal_freq_sel,
  output wire        cpu_hold,
  // avalon-mm slave
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  output wire [1:0]  avs_response,
  // interrupt
  output wire        irq
);

////////////////////////////////////////////////////////////////////////
// pin synchroniser: three stages, edge once stages two and three agree
reg  [2:0] in_sync_ff;
reg        in_level_ff;
wire       in_agree = (in_sync_ff[1] == in_sync_ff[2]);
wire       in_rise  = in_agree & in_sync_ff[2] & ~in_level_ff;
always @(posedge clk_sys) begin
  if (!rst_n) begin
    in_sync_ff  <= 3'h0;
    in_level_ff <= 1'b0;
  end else begin
    in_sync_ff <= {in_sync_ff[1:0], oscillator_in_pin};
    if (in_agree)
      in_level_ff <= in_sync_ff[2];
  end
end

////////////////////////////////////////////////////////////////////////
// mode decode
wire mode_crystal = (clock_mode_config == `OSCMS_MODE_LP) |
                    (clock_mode_config == `OSCMS_MODE_XT) |
                    (clock_mode_config == `OSCMS_MODE_HS);
wire mode_ec      = (clock_mode_config == `OSCMS_MODE_EC);
wire mode_rc      = (clock_mode_config == `OSCMS_MODE_RC);
wire mode_resistor_cap_pin_io_mode    = (clock_mode_config == `OSCMS_MODE_RESISTOR_CAP_PIN_IO_MODE);
wire mode_int     = (clock_mode_config == `OSCMS_MODE_INT);
wire mode_intio   = (clock_mode_config == `OSCMS_MODE_INTIO);
wire mode_ext     = ~(mode_int | mode_intio);

////////////////////////////////////////////////////////////////////////
// control register and bus
reg  [2:0] internal_freq_choice_ff;
reg        scs_ff;
reg  [3:0] irq_stat_ff;
reg  [3:0] irq_en_ff;
reg        running_on_external_flag_ff;
reg        hts_ff;
reg        lts_ff;
wire       wr_ctrl = avs_write & avs_byteenable[0] & (avs_address == `OSCMS_ADDR_CTRL);
wire       wr_en   = avs_write & avs_byteenable[0] & (avs_address == `OSCMS_ADDR_IRQ_EN);
wire       wr_clr  = avs_write & avs_byteenable[0] & (avs_address == `OSCMS_ADDR_IRQ_CLR);
wire [7:0] ctrl_rd = {1'b0, internal_freq_choice_ff, running_on_external_flag_ff, hts_ff, lts_ff, scs_ff};

// reads take one wait state so that the registered read data already
// stand at the edge where the master sees waitrequest low
reg         rd_wait_ff;
reg  [31:0] nxt_readdata;
wire        rd_first = avs_read & ~rd_wait_ff;
assign avs_waitrequest = rd_first;
assign avs_response    = 2'h0;

always @* begin
  nxt_readdata = avs_readdata;
  if (rd_first) begin
    case (avs_address)
      `OSCMS_ADDR_CTRL:     nxt_readdata = {24'h0, ctrl_rd};
      `OSCMS_ADDR_IRQ_STAT: nxt_readdata = {28'h0, irq_stat_ff};
      `OSCMS_ADDR_IRQ_EN:   nxt_readdata = {28'h0, irq_en_ff};
      default:              nxt_readdata = 32'h0;
    endcase
  end
end

always @(posedge clk_sys) begin
  if (!rst_n) begin
    rd_wait_ff   <= 1'b0;
    avs_readdata <= 32'h0;
  end else begin
    // high in the accepting cycle only, so a held read is taken once
    rd_wait_ff   <= rd_first;
    avs_readdata <= nxt_readdata;
  end
end

always @(posedge clk_sys) begin
  if (!rst_n) begin
    internal_freq_choice_ff      <= `OSCMS_INTERNAL_FREQ_CHOICE_RESET;
    scs_ff       <= 1'b0;
    irq_en_ff    <= 4'h0;
  end else begin
    if (wr_ctrl) begin
      // only frequency and select are writable; status bits hold
      internal_freq_choice_ff <= avs_writedata[`OSCMS_F_INTERNAL_FREQ_CHOICE_HI:`OSCMS_F_INTERNAL_FREQ_CHOICE_LO];
      scs_ff  <= avs_writedata[`OSCMS_F_SCS];
    end
    if (wr_en)
      irq_en_ff <= avs_writedata[3:0];
  end
end

////////////////////////////////////////////////////////////////////////
// internal oscillator enables and warm-up
assign fast_osc_enable = (internal_freq_choice_ff != `OSCMS_INTERNAL_FREQ_CHOICE_SLOW) &
                         (scs_ff | two_speed_cfg);
reg  [7:0] hf_warm_ff;
reg  [7:0] lf_warm_ff;
reg        hts_q_ff;
always @(posedge clk_sys) begin
  if (!rst_n) begin
    hf_warm_ff <= 8'h0;
    lf_warm_ff <= 8'h0;
    hts_ff     <= 1'b0;
    lts_ff     <= 1'b0;
    hts_q_ff   <= 1'b0;
  end else begin
    hts_q_ff <= hts_ff;
    // a source that is switched off loses its ok bit on the next edge
    // slow oscillator always runs once out of reset
    if (lf_warm_ff != `OSCMS_LF_WARM_CYCLES)
      lf_warm_ff <= lf_warm_ff + 8'h1;
    lts_ff <= (lf_warm_ff == `OSCMS_LF_WARM_CYCLES);
    if (!fast_osc_enable)
      hf_warm_ff <= 8'h0;
    else if (hf_warm_ff != `OSCMS_HF_WARM_CYCLES)
      hf_warm_ff <= hf_warm_ff + 8'h1;
    hts_ff <= fast_osc_enable & (hf_warm_ff == `OSCMS_HF_WARM_CYCLES);
  end
end

////////////////////////////////////////////////////////////////////////
// start-up sequencer
localparam [4:0] ST_WAIT_PWR = 5'h01;
localparam [4:0] ST_OST      = 5'h02;
localparam [4:0] ST_RUN_INT  = 5'h04;
localparam [4:0] ST_RUN_EXT  = 5'h08;
localparam [4:0] ST_FAILED   = 5'h10;
reg  [4:0]  state_ff;
reg  [4:0]  nxt_state;
reg  [10:0] ost_cnt_ff;
reg  [10:0] nxt_ost_cnt;
reg  [7:0]  fail_cnt_ff;
reg         ost_done_ff;
reg         nxt_ost_done;
wire        int_src_ok   = (internal_freq_choice_ff == `OSCMS_INTERNAL_FREQ_CHOICE_SLOW) ? lts_ff : hts_ff;
wire        two_speed_on = two_speed_cfg & mode_crystal;
wire        ext_fail     = fail_monitor_cfg & mode_ext & (fail_cnt_ff == FAIL_CYCLES);
wire        want_ext     = mode_ext & ~scs_ff & ost_done_ff & ~ext_fail;

// handover guard: a request for the external source must stand three cycles before the source moves,
// so a one-cycle low blip on the select bit cannot cut a clock pulse short
reg  [1:0]  want_ext_q_ff;
wire        want_ext_steady = want_ext & want_ext_q_ff[0] & want_ext_q_ff[1];
always @(posedge clk_sys) begin
  if (!rst_n)
    want_ext_q_ff <= 2'h0;
  else
    want_ext_q_ff <= {want_ext_q_ff[0], want_ext};
end

always @* begin
  nxt_state    = state_ff;
  nxt_ost_cnt  = ost_cnt_ff;
  nxt_ost_done = ost_done_ff;
  case (state_ff)
    ST_WAIT_PWR: begin
      if (power_up_delay_done) begin
        if (mode_crystal) begin
          nxt_state   = ST_OST;
          nxt_ost_cnt = 11'h0;
        end else begin
          nxt_ost_done = 1'b1;
          nxt_state    = ST_RUN_INT;
        end
      end
    end
    ST_OST: begin
      if (in_rise)
        nxt_ost_cnt = ost_cnt_ff + 11'h1;
      if (ost_cnt_ff == `OSCMS_OST_COUNT) begin
        nxt_ost_done = 1'b1;
        nxt_state    = ST_RUN_INT;
      end
    end
    ST_RUN_INT: begin
      // wait for stability before handing over, avoiding a short pulse
      if (want_ext_steady)
        nxt_state = ST_RUN_EXT;
    end
    ST_RUN_EXT: begin
      if (ext_fail)
        nxt_state = ST_FAILED;
      else if (!want_ext && int_src_ok)
        nxt_state = ST_RUN_INT;
    end
    ST_FAILED: begin
      // leave the fallback only once the internal source is settled
      if (!ext_fail && int_src_ok)
        nxt_state = ST_RUN_INT;
    end
    default: nxt_state = ST_WAIT_PWR;
  endcase
  if (wake_from_sleep && mode_crystal) begin
    nxt_state    = ST_OST;
    nxt_ost_cnt  = 11'h0;
    nxt_ost_done = 1'b0;
  end
end

always @(posedge clk_sys) begin
  if (!rst_n) begin
    state_ff    <= ST_WAIT_PWR;
    ost_cnt_ff  <= 11'h0;
    ost_done_ff <= 1'b0;
  end else begin
    state_ff    <= nxt_state;
    ost_cnt_ff  <= nxt_ost_cnt;
    ost_done_ff <= nxt_ost_done;
  end
end

////////////////////////////////////////////////////////////////////////
// clock monitor: cycles since the last input edge, saturating at the limit
always @(posedge clk_sys) begin
  if (!rst_n)
    fail_cnt_ff <= 8'h0;
  else if (in_rise || !mode_ext)
    fail_cnt_ff <= 8'h0;
  else if (fail_cnt_ff != FAIL_CYCLES)
    fail_cnt_ff <= fail_cnt_ff + 8'h1;
end

// the design holds state only in flops; a stalled clock freezes it whole
wire running_ext = (state_ff == ST_RUN_EXT);
always @(posedge clk_sys) begin
  if (!rst_n)
    running_on_external_flag_ff <= 1'b0;
  else
    running_on_external_flag_ff <= running_ext;
end
// reset value is 0 in every configuration, covering two-speed and monitor
assign use_external_clk  = running_on_external_flag_ff;
assign internal_freq_sel = internal_freq_choice_ff;
assign cpu_hold = (state_ff == ST_WAIT_PWR) |
                  ((state_ff == ST_OST) & ~two_speed_on);

////////////////////////////////////////////////////////////////////////
// output pin: quarter-rate divider
reg [1:0] div_ff;
reg       quarter_rate_out_ff;
always @(posedge clk_sys) begin
  if (!rst_n) begin
    div_ff              <= 2'h0;
    quarter_rate_out_ff <= 1'b0;
  end else begin
    div_ff              <= div_ff + 2'h1;
    quarter_rate_out_ff <= div_ff[1];
  end
end
wire quarter_mode = mode_rc | mode_int;
// pin drive registered so that a mode decode glitch never reaches the pin
reg out_o_ff;
reg out_oe_ff;
always @(posedge clk_sys) begin
  if (!rst_n) begin
    out_o_ff  <= 1'b0;
    out_oe_ff <= 1'b0;
  end else begin
    out_o_ff  <= quarter_mode & quarter_rate_out_ff;
    out_oe_ff <= quarter_mode;
  end
end
assign oscillator_out_o  = out_o_ff;
assign oscillator_out_oe = out_oe_ff;
assign osc_out_is_gpio   = mode_ec | mode_resistor_cap_pin_io_mode | mode_intio;
assign osc_in_is_gpio    = mode_int | mode_intio;

////////////////////////////////////////////////////////////////////////
// interrupts: set wins over clear
reg  running_on_external_flag_q_ff;
wire       ev_switched = running_on_external_flag_ff & ~running_on_external_flag_q_ff;
wire       ev_hf_ok    = hts_ff & ~hts_q_ff;
wire       ev_ost_done = ost_done_ff & (state_ff == ST_OST) & (nxt_state != ST_OST);
wire       ev_fail     = ext_fail & running_ext;
wire [3:0] ev_set      = {ev_switched, ev_hf_ok, ev_ost_done, ev_fail};
always @(posedge clk_sys) begin
  if (!rst_n) begin
    irq_stat_ff <= 4'h0;
    running_on_external_flag_q_ff   <= 1'b0;
  end else begin
    running_on_external_flag_q_ff   <= running_on_external_flag_ff;
    irq_stat_ff <= (irq_stat_ff & ~(wr_clr ? avs_writedata[3:0] : 4'h0)) | ev_set;
  end
end
assign irq = |(irq_stat_ff & irq_en_ff);

endmodule
`default_nettype wire

// file: oscms_top_sva.sv
`default_nettype none
module oscms_top_sva #(
  parameter [7:0] FAIL_CYCLES = 8'h40
) (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // configuration
  input wire logic [2:0]  clock_mode_config,
  input wire logic        two_speed_cfg,
  input wire logic        power_up_delay_done,
  // pin roles and status
  input wire logic        osc_in_is_gpio,
  input wire logic        osc_out_is_gpio,
  input wire logic        fast_osc_enable,
  input wire logic        use_external_clk,
  input wire logic [2:0]  internal_freq_sel,
  input wire logic        cpu_hold,
  // register bus
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic [31:0] avs_readdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_in_pin_role: assert property (osc_in_is_gpio == (clock_mode_config[2:1] == 2'b11))
    else $error("input pin role wrong");
  a_out_pin_role: assert property (osc_out_is_gpio == (clock_mode_config inside {3'h3, 3'h4, 3'h6}))
    else $error("output pin role wrong");
  a_fast_osc_off: assert property (internal_freq_sel == 3'h0 |-> !fast_osc_enable)
    else $error("fast oscillator on at slow setting");
  a_fast_osc_on: assert property (two_speed_cfg && internal_freq_sel != 3'h0 |-> fast_osc_enable)
    else $error("fast oscillator off with two-speed start");
  a_freq_reset_val: assert property ($rose(rst_n) |-> internal_freq_sel == 3'h6)
    else $error("frequency field reset value wrong");
  a_ext_flag_reset: assert property ($rose(rst_n) |-> !use_external_clk)
    else $error("external flag not clear after reset");
  a_top_bit_zero: assert property (avs_read && avs_address == 4'h0 |=> !avs_readdata[7])
    else $error("top control bit reads one");
  a_driven_no_wait: assert property (
    clock_mode_config == 3'h3 && $rose(power_up_delay_done) |-> ##[0:2] !cpu_hold)
    else $error("driven clock mode still held");
  c_hold_done: cover property ($fell(cpu_hold));
  c_ext_lost: cover property ($fell(use_external_clk));
  c_fast_on: cover property ($rose(fast_osc_enable));
endmodule
bind oscms_top oscms_top_sva #(.FAIL_CYCLES(FAIL_CYCLES)) oscms_top_sva_inst (.clk_sys,
  .rst_n, .clock_mode_config, .two_speed_cfg, .power_up_delay_done, .osc_in_is_gpio,
  .osc_out_is_gpio, .fast_osc_enable, .use_external_clk, .internal_freq_sel, .cpu_hold,
  .avs_address, .avs_read, .avs_readdata);
`default_nettype wire

// file: oscms_osc_model.sv
`default_nettype none
module oscms_osc_model #(
  parameter int HALF = 2
) (
  // timing reference and run control
  input  wire logic clk_sys,
  input  wire logic run,
  // source output seen at the input pin
  output var  logic osc
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_ff;
  initial begin
    osc = 1'b0;
    cnt_ff = 0;
  end
  // a stopped source holds its level, so no edge reaches the failure monitor
  always @(posedge clk_sys) begin
    if (run) begin
      cnt_ff <= (cnt_ff >= HALF - 1) ? 0 : cnt_ff + 1;
      if (cnt_ff >= HALF - 1) osc <= ~osc;
    end
  end
endmodule
`default_nettype wire

// file: tb_oscms_top.sv
`default_nettype none
module tb_oscms_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [2:0]  clock_mode_config = 3'h3;
  logic        two_speed_cfg = 1'b0;
  logic        fail_monitor_cfg = 1'b1;
  logic        power_up_delay_done = 1'b0;
  logic        wake_from_sleep = 1'b0;
  logic        osc_run = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] rd_data;
  wire [31:0]  avs_readdata;
  wire [2:0]   internal_freq_sel;
  wire [1:0]   avs_response;
  wire oscillator_in_pin, oscillator_out_o, oscillator_out_oe, osc_in_is_gpio, osc_out_is_gpio;
  wire fast_osc_enable, use_external_clk, cpu_hold, avs_waitrequest, irq;
  int failures = 0;
  int checks_done = 0;
  int e;
  always #5 clk_sys = ~clk_sys;
  oscms_top #(.FAIL_CYCLES(8'h10)) oscms_top_inst (.clk_sys, .rst_n, .clock_mode_config,
    .two_speed_cfg, .fail_monitor_cfg, .power_up_delay_done, .wake_from_sleep,
    .oscillator_in_pin, .oscillator_out_o, .oscillator_out_oe, .osc_in_is_gpio,
    .osc_out_is_gpio, .fast_osc_enable, .use_external_clk, .internal_freq_sel, .cpu_hold,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf),
    .avs_readdata, .avs_waitrequest, .avs_response, .irq);
  oscms_osc_model #(.HALF(2)) oscms_osc_model_inst (.clk_sys, .run(osc_run),
    .osc(oscillator_in_pin));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // called just after a rising edge; waitrequest and read data are looked at
  // mid-cycle, so the values taken are those of the accepting edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    logic ws;
    k = 0;
    ws = 1'b1;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    while (ws && k < 50) begin
      @(negedge clk_sys);
      ws = (avs_waitrequest !== 1'b0);
      rd_data = avs_readdata;
      @(posedge clk_sys);
      k++;
    end
    if (ws) chk(1'b0, 1'b1, "bus timeout");
    if (ws) results();
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask
  // counts source rising edges until hold reaches lvl
  task automatic wait_hold(input logic lvl, input int lim);
    logic prev;
    e = 0;
    prev = oscillator_in_pin;
    while (cpu_hold !== lvl && lim > 0) begin
      @(posedge clk_sys);
      e += int'(oscillator_in_pin && !prev);
      prev = oscillator_in_pin;
      lim--;
    end
    if (lim == 0) chk(1'b0, 1'b1, "hold wait timeout");
    if (lim == 0) results();
  endtask
  task automatic wait_ext(input logic lvl);
    int k;
    for (k = 0; k < 300 && use_external_clk !== lvl; k++) @(posedge clk_sys);
    chk(use_external_clk, lvl, "external flag");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk(cpu_hold, 1'b1, "hold before power-up");
    bus(1'b0, 4'h0, 32'h0);
    chk(rd_data & 32'hf9, 32'h60, "control reset");
    bus(1'b0, 4'h5, 32'h0);
    chk(rd_data, 32'h0, "unmapped read");
    chk(avs_response, 2'h0, "bus response");
    power_up_delay_done <= 1'b1;
    @(posedge clk_sys);
    wait_hold(1'b0, 4);
    wait_ext(1'b1);
    bus(1'b1, 4'h0, 32'hff);
    repeat (30) @(posedge clk_sys);
    bus(1'b0, 4'h0, 32'h0);
    chk(rd_data, 32'h77, "internal select");
    chk(use_external_clk, 1'b0, "flag on internal");
    two_speed_cfg <= 1'b1;
    for (int f = 0; f < 8; f++) begin
      bus(1'b1, 4'h0, 32'(f << 4));
      chk(internal_freq_sel, f[2:0], "frequency field");
      chk(fast_osc_enable, f != 0, "fast enable");
    end
    two_speed_cfg <= 1'b0;
    bus(1'b1, 4'h0, 32'h60);
    wait_ext(1'b1);
    bus(1'b1, 4'h8, 32'hf);
    bus(1'b1, 4'hc, 32'hf);
    chk(irq, 1'b0, "irq idle");
    osc_run <= 1'b0;
    wait_ext(1'b0);
    chk(irq, 1'b1, "irq on failure");
    bus(1'b0, 4'h4, 32'h0);
    chk(rd_data[0], 1'b1, "failure status");
    bus(1'b1, 4'h8, 32'h0);
    chk(irq, 1'b0, "irq masked");
    bus(1'b1, 4'hc, 32'h1);
    bus(1'b0, 4'h4, 32'h0);
    chk(rd_data[0], 1'b0, "status cleared");
    osc_run <= 1'b1;
    rst_n <= 1'b0;
    clock_mode_config <= 3'h1;
    power_up_delay_done <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    power_up_delay_done <= 1'b1;
    wait_hold(1'b0, 6000);
    chk(e >= 1023 && e <= 1026, 1'b1, "crystal count");
    wake_from_sleep <= 1'b1;
    @(posedge clk_sys);
    wake_from_sleep <= 1'b0;
    wait_hold(1'b1, 4);
    wait_hold(1'b0, 6000);
    chk(e >= 1023 && e <= 1026, 1'b1, "count after wake");
    wait_ext(1'b1);
    for (int m = 0; m < 8; m++) begin
      int hi;
      clock_mode_config <= m[2:0];
      hi = 0;
      repeat (4) @(posedge clk_sys);
      repeat (8) begin
        @(posedge clk_sys);
        hi += int'(oscillator_out_o);
      end
      chk({osc_in_is_gpio, osc_out_is_gpio, oscillator_out_oe},
        {((8'hc0 >> m) & 8'h1) != 8'h0, ((8'h58 >> m) & 8'h1) != 8'h0,
         ((8'ha0 >> m) & 8'h1) != 8'h0}, "pin roles");
      chk(hi, (m == 5 || m == 7) ? 4 : 0, "quarter rate");
    end
    results();
  end
endmodule
`default_nettype wire
